/* File: shared/wake_irq_pkg.sv */
// constants for the wake-up and interrupt dispatch block
package wake_irq_pkg;
  // register byte offsets
  localparam logic [4:0] OFS_IRQ_EN     = 5'h00;
  localparam logic [4:0] OFS_WAKE_EN    = 5'h04;
  localparam logic [4:0] OFS_FLAGS      = 5'h08;
  localparam logic [4:0] OFS_ADC_CTRL   = 5'h0c;
  localparam logic [4:0] OFS_VOLT       = 5'h10;
  localparam logic [4:0] OFS_WDOG       = 5'h14;
  localparam logic [4:0] OFS_STATUS     = 5'h18;
  // interrupt enable and flag bit positions
  localparam int BIT_OVERFLOW   = 0;
  localparam int BIT_PIN_CHANGE = 1;
  localparam int BIT_CONV       = 3;
  localparam int BIT_COMPARE    = 7;
  localparam logic [7:0] IRQ_MASK = 8'h8b;
  // wake enable bit positions
  localparam int WBIT_PIN_CHANGE = 0;
  localparam int WBIT_COMPARE    = 1;
  localparam int WBIT_CONV       = 2;
  localparam logic [7:0] WAKE_MASK = 8'h07;
  // voltage detect register bits
  localparam int VBIT_WAKE = 3;
  localparam int VBIT_IRQ  = 4;
  localparam int VBIT_FLAG = 6;
  // adc control, watchdog control, status bits
  localparam int ABIT_RUN       = 7;
  localparam int DBIT_WDOG_EN   = 7;
  localparam int SBIT_ASLEEP    = 0;
  localparam int SBIT_GLOBAL    = 1;
  localparam int SBIT_CLOCKS    = 2;
  // vectors
  localparam logic [7:0] VEC_RESET      = 8'h00;
  localparam logic [7:0] VEC_PIN_CHANGE = 8'h06;
  localparam logic [7:0] VEC_OVERFLOW   = 8'h09;
  localparam logic [7:0] VEC_CONV       = 8'h0c;
  localparam logic [7:0] VEC_COMPARE    = 8'h0f;
  localparam logic [7:0] VEC_LOW_VOLT   = 8'h18;
  // bus responses and reset values
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] REG_RESET   = 8'h00;
  typedef enum logic [0:0] {ST_RUN = 1'b0, ST_SLEEP = 1'b1} power_state_t;
endpackage : wake_irq_pkg

/* File: rtl/sleep_wakeup_interrupt_control.sv */
// wake-up and interrupt dispatch with axi4-lite register access
// Summary of operation
// - timer overflow, enable set, global off: set flag, continue next instruction
// - timer overflow, enable set, global on: set flag, vector 0x09; no sleep wake
// - sleep without conversion wake or irq enable: stop converter, clear running, no wake
// - sleep, conversion irq enable only: set flag, clear running, halt, stay asleep
// - conversion wake enable keeps clocks running in sleep, wakes on completion
// - conversion wake and irq enable, global off: wake, set flag, next instruction
// - conversion wake and irq enable, global on: set flag, vector 0x0c
// - normal mode conversion: no flag without enable; global off means flag only
// - comparator with both enables clear: no wake, no interrupt
// - sleep, comparator irq enable only: set flag, stay asleep
// - sleep, comparator wake only: wake, next instruction, no flag
// - comparator irq enable, global off: flag, next instruction; wakes if enabled
// - comparator irq enable, global on: flag and vector 0x0f, after wake
// - low-voltage events ignored when both its enables are clear
// - sleep, low-voltage irq enable only: set flag, stay asleep
// - sleep, low-voltage wake only: wake, next instruction
// - low-voltage irq enable, global off: flag, next instruction, wake if enabled
// - low-voltage irq enable, global on: flag and vector 0x18, after wake
// - enabled watchdog timeout: wake if asleep, reset to address 0x00
// - sleep, pin-change wake, irq enable, global on: wake, flag, vector 0x06
// - pin-change irq enable, global off: flag, next instruction, no vector
`timescale 1ns/1ps
`default_nettype none
module sleep_wakeup_interrupt_control
  import wake_irq_pkg::*;
#(
  parameter int ADDR_W = 5
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              global_irq_on_instr,
  input  wire logic              global_irq_off_instr,
  input  wire logic              sleep_instr,
  input  wire logic              overflow_evt,
  input  wire logic              pin_change_evt,
  input  wire logic              conv_done_evt,
  input  wire logic              compare_evt,
  input  wire logic              low_volt_evt,
  input  wire logic              watchdog_timeout,
  output var  logic              wake,
  output var  logic              vector_req,
  output var  logic [7:0]        vector_addr,
  output var  logic              reset_req,
  output var  logic              conv_halt,
  output var  logic              asleep,
  output var  logic              clocks_run,
  output var  logic              conv_running
);

  if (ADDR_W < 5 || ADDR_W > 32)
  begin : g_bad_addr
    $error("ADDR_W must lie between 5 and 32");
  end

  typedef struct packed {
    power_state_t      state;
    logic              global_en;
    logic [7:0]        irq_en;
    logic [7:0]        wake_en;
    logic [7:0]        flags;
    logic              conv_run;
    logic              low_volt_wake_en;
    logic              low_volt_irq_en;
    logic              low_volt_flag;
    logic              watchdog_en;
    logic              wake;
    logic              vector_req;
    logic [7:0]        vector_addr;
    logic              reset_req;
    logic              conv_halt;
    logic              clocks_run;
    logic              awready;
    logic              wready;
    logic              arready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              aw_held;
    logic [ADDR_W-1:0] awaddr;
    logic              w_held;
    logic [7:0]        wdata;
    logic              wlane0;
  } state_t;

  state_t s;
  state_t next_s;

  function automatic logic [7:0] pick_vector(input logic [4:0] pend);
    logic [7:0] v;
    v = VEC_LOW_VOLT;
    if (pend[0])
      v = VEC_PIN_CHANGE;
    else if (pend[1])
      v = VEC_OVERFLOW;
    else if (pend[2])
      v = VEC_CONV;
    else if (pend[3])
      v = VEC_COMPARE;
    return v;
  endfunction : pick_vector

  function automatic logic [4:0] low_addr(input logic [ADDR_W-1:0] a);
    return a[4:0];
  endfunction : low_addr

  logic       in_sleep;
  logic       wdt_hit;
  logic       wake_hit;
  logic [7:0] flag_set;
  logic [4:0] pending;

  assign in_sleep = (s.state == ST_SLEEP);
  assign wdt_hit  = watchdog_timeout && s.watchdog_en;
  assign pending  = {s.low_volt_flag && s.low_volt_irq_en,
                     s.flags[BIT_COMPARE] && s.irq_en[BIT_COMPARE],
                     s.flags[BIT_CONV] && s.irq_en[BIT_CONV],
                     s.flags[BIT_OVERFLOW] && s.irq_en[BIT_OVERFLOW],
                     s.flags[BIT_PIN_CHANGE] && s.irq_en[BIT_PIN_CHANGE]};

  always_comb
  begin
    logic       wr_go;
    logic [4:0] wa;
    logic [4:0] ra;
    logic [7:0] clr;
    logic       volt_clr;
    logic       volt_set;
    wr_go    = 1'b0;
    wa       = 5'h00;
    ra       = 5'h00;
    clr      = 8'h00;
    volt_clr = 1'b0;
    volt_set = 1'b0;
    next_s   = s;
    next_s.wake       = 1'b0;
    next_s.vector_req = 1'b0;
    next_s.reset_req  = 1'b0;
    next_s.conv_halt  = 1'b0;

    // flags per source, timer stopped in sleep
    // overflow flag when enabled
    flag_set = 8'h00;
    flag_set[BIT_OVERFLOW]   = overflow_evt && !in_sleep && s.irq_en[BIT_OVERFLOW];
    flag_set[BIT_PIN_CHANGE] = pin_change_evt && s.irq_en[BIT_PIN_CHANGE];
    flag_set[BIT_CONV]       = conv_done_evt && s.irq_en[BIT_CONV];
    flag_set[BIT_COMPARE]    = compare_evt && s.irq_en[BIT_COMPARE];
    volt_set = low_volt_evt && s.low_volt_irq_en;

    wake_hit = in_sleep && ((pin_change_evt && s.wake_en[WBIT_PIN_CHANGE]) ||
                            (compare_evt && s.wake_en[WBIT_COMPARE]) ||
                            (conv_done_evt && s.wake_en[WBIT_CONV]) ||
                            (low_volt_evt && s.low_volt_wake_en) || wdt_hit);

    if (global_irq_on_instr)
      next_s.global_en = 1'b1;
    else if (global_irq_off_instr)
      next_s.global_en = 1'b0;

    if (conv_done_evt)
      next_s.conv_run = 1'b0;

    if (sleep_instr && !in_sleep && !wdt_hit)
    begin
      next_s.state = ST_SLEEP;
      if (s.conv_run && !s.wake_en[WBIT_CONV])
      begin
        next_s.conv_run  = 1'b0;
        next_s.conv_halt = 1'b1;
        flag_set[BIT_CONV] = s.irq_en[BIT_CONV];
      end
    end

    if (wake_hit)
    begin
      next_s.state = ST_RUN;
      next_s.wake  = 1'b1;
    end

    if (wdt_hit)
    begin
      next_s.reset_req   = 1'b1;
      next_s.vector_addr = VEC_RESET;
      next_s.global_en   = 1'b0;
    end
    // vector only in run with global on
    else if (!in_sleep && s.global_en && (pending != 5'h00))
    begin
      next_s.vector_req  = 1'b1;
      next_s.vector_addr = pick_vector(pending);
      next_s.global_en   = 1'b0;
    end

    // write channel capture, either order
    if (s_axi_awvalid && s.awready)
    begin
      next_s.aw_held = 1'b1;
      next_s.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready)
    begin
      next_s.w_held = 1'b1;
      next_s.wdata  = s_axi_wdata[7:0];
      next_s.wlane0 = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready)
      next_s.bvalid = 1'b0;

    if (next_s.aw_held && next_s.w_held && !next_s.bvalid)
    begin
      wr_go          = next_s.wlane0;
      wa             = low_addr(next_s.awaddr);
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = RESP_OKAY;
      if (wa != OFS_IRQ_EN && wa != OFS_WAKE_EN && wa != OFS_FLAGS &&
          wa != OFS_ADC_CTRL && wa != OFS_VOLT && wa != OFS_WDOG && wa != OFS_STATUS)
        next_s.bresp = RESP_SLVERR;
    end

    if (wr_go)
    begin
      if (wa == OFS_IRQ_EN)
        next_s.irq_en = next_s.wdata & IRQ_MASK;
      else if (wa == OFS_WAKE_EN)
        next_s.wake_en = next_s.wdata & WAKE_MASK;
      else if (wa == OFS_FLAGS)
        clr = next_s.wdata & IRQ_MASK;
      else if (wa == OFS_ADC_CTRL)
        next_s.conv_run = next_s.wdata[ABIT_RUN] && !conv_done_evt;
      else if (wa == OFS_VOLT)
      begin
        next_s.low_volt_wake_en = next_s.wdata[VBIT_WAKE];
        next_s.low_volt_irq_en  = next_s.wdata[VBIT_IRQ];
        volt_clr                = next_s.wdata[VBIT_FLAG];
      end
      else if (wa == OFS_WDOG)
        next_s.watchdog_en = next_s.wdata[DBIT_WDOG_EN];
    end

    next_s.flags         = (s.flags & ~clr) | flag_set;
    next_s.low_volt_flag = (s.low_volt_flag && !volt_clr) || volt_set;

    // read channel
    if (s.rvalid && s_axi_rready)
      next_s.rvalid = 1'b0;
    if (s_axi_arvalid && s.arready)
    begin
      ra            = low_addr(s_axi_araddr);
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      next_s.rdata  = 32'h0000_0000;
      if (ra == OFS_IRQ_EN)
        next_s.rdata[7:0] = s.irq_en;
      else if (ra == OFS_WAKE_EN)
        next_s.rdata[7:0] = s.wake_en;
      else if (ra == OFS_FLAGS)
        next_s.rdata[7:0] = s.flags;
      else if (ra == OFS_ADC_CTRL)
        next_s.rdata[ABIT_RUN] = s.conv_run;
      else if (ra == OFS_VOLT)
      begin
        next_s.rdata[VBIT_WAKE] = s.low_volt_wake_en;
        next_s.rdata[VBIT_IRQ]  = s.low_volt_irq_en;
        next_s.rdata[VBIT_FLAG] = s.low_volt_flag;
      end
      else if (ra == OFS_WDOG)
        next_s.rdata[DBIT_WDOG_EN] = s.watchdog_en;
      else if (ra == OFS_STATUS)
      begin
        next_s.rdata[SBIT_ASLEEP] = in_sleep;
        next_s.rdata[SBIT_GLOBAL] = s.global_en;
        next_s.rdata[SBIT_CLOCKS] = s.clocks_run;
      end
      else
        next_s.rresp = RESP_SLVERR;
    end

    next_s.awready = !next_s.aw_held && !next_s.bvalid;
    next_s.wready  = !next_s.w_held && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;
    next_s.clocks_run = (next_s.state == ST_RUN) ||
                        (next_s.conv_run && next_s.wake_en[WBIT_CONV]);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s            <= '0;
      s.state      <= ST_RUN;
      s.irq_en     <= REG_RESET;
      s.wake_en    <= REG_RESET;
      s.flags      <= REG_RESET;
      s.clocks_run <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready  = s.wready;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign wake          = s.wake;
  assign vector_req    = s.vector_req;
  assign vector_addr   = s.vector_addr;
  assign reset_req     = s.reset_req;
  assign conv_halt     = s.conv_halt;
  assign asleep        = in_sleep;
  assign clocks_run    = s.clocks_run;
  assign conv_running  = s.conv_run;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_pin_cause;
    in_sleep && pin_change_evt && s.wake_en[WBIT_PIN_CHANGE] &&
      s.irq_en[BIT_PIN_CHANGE] && s.global_en && !global_irq_off_instr && !wdt_hit;
  endsequence
  sequence s_wake_out;
    wake && !in_sleep;
  endsequence

  property p_overflow_flag;
    overflow_evt && !in_sleep && s.irq_en[BIT_OVERFLOW] |=> s.flags[BIT_OVERFLOW];
  endproperty
  a_overflow_flag: assert property (p_overflow_flag)
    else $error("overflow flag not set");

  property p_overflow_vector;
    !in_sleep && s.global_en && !wdt_hit && pending == 5'h02 |=>
      vector_req && vector_addr == VEC_OVERFLOW;
  endproperty
  a_overflow_vector: assert property (p_overflow_vector)
    else $error("overflow vector wrong");

  property p_conv_halt;
    sleep_instr && !in_sleep && !wdt_hit && s.conv_run && !s.wake_en[WBIT_CONV] |=>
      conv_halt && !conv_running && in_sleep;
  endproperty
  a_conv_halt: assert property (p_conv_halt)
    else $error("converter not halted on sleep");

  property p_conv_no_wake;
    in_sleep && conv_done_evt && !s.wake_en[WBIT_CONV] && s.irq_en[BIT_CONV] &&
      !pin_change_evt && !compare_evt && !low_volt_evt && !wdt_hit |=>
      in_sleep && !wake && s.flags[BIT_CONV];
  endproperty
  a_conv_no_wake: assert property (p_conv_no_wake)
    else $error("conversion woke or flag missing");

  property p_conv_wake;
    in_sleep && conv_done_evt && s.wake_en[WBIT_CONV] |=> s_wake_out;
  endproperty
  a_conv_wake: assert property (p_conv_wake)
    else $error("conversion did not wake");

  property p_clocks;
    in_sleep && conv_running && s.wake_en[WBIT_CONV] |-> clocks_run;
  endproperty
  a_clocks: assert property (p_clocks)
    else $error("clocks stopped during conversion wake");

  property p_compare_quiet;
    compare_evt && !s.flags[BIT_COMPARE] && !s.irq_en[BIT_COMPARE] |=>
      !s.flags[BIT_COMPARE];
  endproperty
  a_compare_quiet: assert property (p_compare_quiet)
    else $error("comparator flag set while disabled");

  property p_compare_wake;
    in_sleep && compare_evt && s.wake_en[WBIT_COMPARE] |=> s_wake_out;
  endproperty
  a_compare_wake: assert property (p_compare_wake)
    else $error("comparator did not wake");

  property p_low_volt_flag;
    low_volt_evt && s.low_volt_irq_en |=> s.low_volt_flag;
  endproperty
  a_low_volt_flag: assert property (p_low_volt_flag)
    else $error("low-voltage flag not set");

  property p_watchdog;
    wdt_hit |=> reset_req && !in_sleep && !vector_req && vector_addr == VEC_RESET;
  endproperty
  a_watchdog: assert property (p_watchdog)
    else $error("watchdog reset missing");

  property p_pin_vector;
    s_pin_cause ##1 !wdt_hit |=> vector_req && vector_addr == VEC_PIN_CHANGE;
  endproperty
  a_pin_vector: assert property (p_pin_vector)
    else $error("pin change vector missing");

  property p_no_vector_off;
    !s.global_en |=> !vector_req;
  endproperty
  a_no_vector_off: assert property (p_no_vector_off)
    else $error("vector taken with interrupts off");

endmodule : sleep_wakeup_interrupt_control
`default_nettype wire

/* File: test/core_event_model.sv */
// core sequencer and event source model
`timescale 1ns/1ps
`default_nettype none
module core_event_model (
  input  wire logic aclk,
  output var  logic global_irq_on_instr,
  output var  logic global_irq_off_instr,
  output var  logic sleep_instr,
  output var  logic overflow_evt,
  output var  logic pin_change_evt,
  output var  logic conv_done_evt,
  output var  logic compare_evt,
  output var  logic low_volt_evt,
  output var  logic watchdog_timeout
);
  logic [8:0] pulses = 9'h000;
  assign {watchdog_timeout, low_volt_evt, compare_evt, conv_done_evt, pin_change_evt,
          overflow_evt, sleep_instr, global_irq_off_instr, global_irq_on_instr} = pulses;
  // one-cycle strobe, outputs settled on return
  task automatic fire(input logic [8:0] m);
    @(posedge aclk);
    pulses <= m;
    @(posedge aclk);
    pulses <= 9'h000;
    #1;
  endtask : fire
endmodule : core_event_model
`default_nettype wire

/* File: test/test_sleep_wakeup_interrupt_control.sv */
// testbench for the wake-up and interrupt dispatch block
`timescale 1ns/1ps
`default_nettype none
module test_sleep_wakeup_interrupt_control;
  import wake_irq_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        global_irq_on_instr, global_irq_off_instr, sleep_instr, overflow_evt;
  logic        pin_change_evt, conv_done_evt, compare_evt, low_volt_evt, watchdog_timeout;
  logic        wake, vector_req, reset_req, conv_halt, asleep, clocks_run, conv_running;
  logic [7:0]  vector_addr;
  logic [1:0]  last_bresp;
  int          fails = 0;
  int          compares = 0;
  int          ibit [5] = '{BIT_OVERFLOW, BIT_PIN_CHANGE, BIT_CONV, BIT_COMPARE, VBIT_FLAG};
  int          wbit [5] = '{WBIT_PIN_CHANGE, WBIT_PIN_CHANGE, WBIT_CONV, WBIT_COMPARE, 0};
  logic [7:0]  vecs [5] = '{VEC_OVERFLOW, VEC_PIN_CHANGE, VEC_CONV, VEC_COMPARE, VEC_LOW_VOLT};

  always #12.5 aclk = ~aclk;

  sleep_wakeup_interrupt_control #(.ADDR_W(5)) u_sleep_wakeup_interrupt_control (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .global_irq_on_instr, .global_irq_off_instr,
    .sleep_instr, .overflow_evt, .pin_change_evt, .conv_done_evt, .compare_evt,
    .low_volt_evt, .watchdog_timeout, .wake, .vector_req, .vector_addr, .reset_req,
    .conv_halt, .asleep, .clocks_run, .conv_running);

  core_event_model u_core_event_model (
    .aclk, .global_irq_on_instr, .global_irq_off_instr, .sleep_instr, .overflow_evt,
    .pin_change_evt, .conv_done_evt, .compare_evt, .low_volt_evt, .watchdog_timeout);

  task automatic conclude;
    if (fails == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    int   n;
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    n  = 0;
    tb = 1'b0;
    while (!tb && n < 100)
    begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      last_bresp = s_axi_bresp;
      @(posedge aclk);
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
      if (tb)
        s_axi_bready <= 1'b0;
      n++;
    end
    if (!tb)
    begin
      fails++;
      conclude();
    end
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    int   n;
    logic ta, tr;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    n  = 0;
    tr = 1'b0;
    while (!tr && n < 100)
    begin
      @(negedge aclk);
      ta = s_axi_arready;
      tr = s_axi_rvalid;
      d  = s_axi_rdata;
      r  = s_axi_rresp;
      @(posedge aclk);
      if (ta)
        s_axi_arvalid <= 1'b0;
      if (tr)
        s_axi_rready <= 1'b0;
      n++;
    end
    if (!tr)
    begin
      fails++;
      conclude();
    end
  endtask : rd

  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : do_reset

  // src: 0 overflow, 1 pin change, 2 conversion, 3 comparator, 4 low voltage
  task automatic ev_case(input int src, input logic slp, we, ie, gl);
    logic [31:0] d;
    logic [1:0]  r;
    logic        xw, xv, xf;
    xf = ie && !(slp && src == 0);
    xw = slp && we && src != 0;
    xv = ie && gl && (!slp || xw);
    do_reset();
    if (src == 4)
      wr(OFS_VOLT, (32'(ie) << VBIT_IRQ) | (32'(we) << VBIT_WAKE));
    else
    begin
      wr(OFS_IRQ_EN, 32'(ie) << ibit[src]);
      wr(OFS_WAKE_EN, 32'(we) << wbit[src]);
    end
    if (src == 2)
      wr(OFS_ADC_CTRL, 32'h80);
    if (gl)
      u_core_event_model.fire(9'h001);
    if (slp)
    begin
      u_core_event_model.fire(9'h004);
      chk("asleep", 32'h1, 32'(asleep));
      chk("clocks_run", 32'(src == 2 && we), 32'(clocks_run));
    end
    u_core_event_model.fire(9'h008 << src);
    chk("wake", 32'(xw), 32'(wake));
    chk("conv_running", 32'h0, 32'(conv_running));
    @(posedge aclk);
    #1;
    chk("vector_req", 32'(xv), 32'(vector_req));
    if (xv)
      chk("vector_addr", 32'(vecs[src]), 32'(vector_addr));
    rd(src == 4 ? OFS_VOLT : OFS_FLAGS, d, r);
    chk("event flag", 32'(xf), 32'(d[ibit[src]]));
  endtask : ev_case

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rd(OFS_STATUS, d, r);
    chk("status", 32'h4, d);
    wr(OFS_IRQ_EN, 32'hff);
    chk("bresp", 32'(RESP_OKAY), 32'(last_bresp));
    s_axi_wstrb <= 4'h0;
    wr(OFS_IRQ_EN, 32'h00);
    s_axi_wstrb <= 4'hf;
    rd(OFS_IRQ_EN, d, r);
    chk("irq enable", 32'(IRQ_MASK), d);
    rd(5'h1c, d, r);
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(r));
    wr(5'h1c, 32'h0);
    chk("unmapped bresp", 32'(RESP_SLVERR), 32'(last_bresp));
  endtask : t_regs

  task automatic t_overflow;
    ev_case(0, 1'b0, 1'b0, 1'b1, 1'b0);
    ev_case(0, 1'b0, 1'b0, 1'b1, 1'b1);
    ev_case(0, 1'b1, 1'b1, 1'b1, 1'b1);
  endtask : t_overflow

  task automatic halt_case(input logic ie);
    logic [31:0] d;
    logic [1:0]  r;
    do_reset();
    wr(OFS_IRQ_EN, 32'(ie) << BIT_CONV);
    wr(OFS_ADC_CTRL, 32'h80);
    chk("conv_running", 32'h1, 32'(conv_running));
    u_core_event_model.fire(9'h004);
    chk("conv_halt", 32'h1, 32'(conv_halt));
    chk("clocks_run", 32'h0, 32'(clocks_run));
    chk("conv_running", 32'h0, 32'(conv_running));
    rd(OFS_ADC_CTRL, d, r);
    chk("running bit", 32'h0, 32'(d[ABIT_RUN]));
    rd(OFS_FLAGS, d, r);
    chk("conv flag", 32'(ie), 32'(d[BIT_CONV]));
  endtask : halt_case

  task automatic t_conv;
    halt_case(1'b0);
    halt_case(1'b1);
    ev_case(2, 1'b1, 1'b0, 1'b1, 1'b0);
    ev_case(2, 1'b1, 1'b1, 1'b0, 1'b0);
    ev_case(2, 1'b1, 1'b1, 1'b1, 1'b0);
    ev_case(2, 1'b1, 1'b1, 1'b1, 1'b1);
    ev_case(2, 1'b0, 1'b0, 1'b1, 1'b1);
    ev_case(2, 1'b0, 1'b0, 1'b0, 1'b1);
    ev_case(2, 1'b0, 1'b0, 1'b1, 1'b0);
  endtask : t_conv

  task automatic t_compare;
    ev_case(3, 1'b1, 1'b0, 1'b0, 1'b1);
    ev_case(3, 1'b0, 1'b0, 1'b0, 1'b1);
    ev_case(3, 1'b1, 1'b0, 1'b1, 1'b1);
    ev_case(3, 1'b1, 1'b1, 1'b0, 1'b0);
    ev_case(3, 1'b1, 1'b1, 1'b1, 1'b0);
    ev_case(3, 1'b1, 1'b1, 1'b1, 1'b1);
  endtask : t_compare

  task automatic t_low_volt;
    ev_case(4, 1'b1, 1'b0, 1'b0, 1'b1);
    ev_case(4, 1'b1, 1'b0, 1'b1, 1'b1);
    ev_case(4, 1'b1, 1'b1, 1'b0, 1'b0);
    ev_case(4, 1'b1, 1'b1, 1'b1, 1'b0);
    ev_case(4, 1'b1, 1'b1, 1'b1, 1'b1);
    ev_case(4, 1'b0, 1'b0, 1'b1, 1'b1);
  endtask : t_low_volt

  task automatic t_pin;
    ev_case(1, 1'b1, 1'b1, 1'b1, 1'b1);
    ev_case(1, 1'b0, 1'b0, 1'b1, 1'b0);
    ev_case(1, 1'b1, 1'b1, 1'b1, 1'b0);
  endtask : t_pin

  task automatic t_watchdog;
    do_reset();
    u_core_event_model.fire(9'h100);
    chk("reset_req off", 32'h0, 32'(reset_req));
    wr(OFS_WDOG, 32'h80);
    u_core_event_model.fire(9'h004);
    u_core_event_model.fire(9'h100);
    chk("wdog wake", 32'h1, 32'(wake));
    chk("reset_req", 32'h1, 32'(reset_req));
    chk("reset addr", 32'(VEC_RESET), 32'(vector_addr));
  endtask : t_watchdog

  task automatic t_clear;
    logic [31:0] d;
    logic [1:0]  r;
    ev_case(3, 1'b0, 1'b0, 1'b1, 1'b0);
    wr(OFS_FLAGS, 32'h80);
    rd(OFS_FLAGS, d, r);
    chk("flag cleared", 32'h0, d);
    u_core_event_model.fire(9'h001);
    @(posedge aclk);
    #1;
    chk("stale vector", 32'h0, 32'(vector_req));
    u_core_event_model.fire(9'h002);
    u_core_event_model.fire(9'h040);
    @(posedge aclk);
    #1;
    chk("vector off", 32'h0, 32'(vector_req));
  endtask : t_clear

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_overflow();
    t_conv();
    t_compare();
    t_low_volt();
    t_pin();
    t_watchdog();
    t_clear();
    conclude();
  end
endmodule : test_sleep_wakeup_interrupt_control
`default_nettype wire
